// *** aeqc_defines.vh ***
// register map, field positions, reset values and timing for the equalizer control block
`ifndef AEQC_DEFINES_VH
`define AEQC_DEFINES_VH

`define AEQC_ADDR_RSVD_BF 8'hbf
`define AEQC_ADDR_TEST_CTL 8'hd0
`define AEQC_ADDR_ADAPT_CTL 8'hd2
`define AEQC_ADDR_READBACK 8'hd3
`define AEQC_ADDR_MANUAL 8'hd4
`define AEQC_ADDR_LIMITS 8'hd5

`define AEQC_RST_RSVD_BF 8'h00
`define AEQC_RST_TEST_HI 2'h0
`define AEQC_RST_RELOCK 3'h4
`define AEQC_RST_FIRST_LOCK 1'h1
`define AEQC_RST_FLOOR_EN 1'h1
`define AEQC_RST_MAN_HI 3'h3
`define AEQC_RST_MAN_LO 3'h0
`define AEQC_RST_LOCK_WAIT 1'h0
`define AEQC_RST_BYPASS 1'h0
`define AEQC_RST_MAX 4'hf
`define AEQC_RST_FLOOR 4'h2
`define AEQC_RST_SETTING 6'h00

`define AEQC_F_TEST_HI 7:6
`define AEQC_B_SELFTEST 5
`define AEQC_B_INJ_CONT 1
`define AEQC_B_INJ_ONCE 0
`define AEQC_F_RELOCK 7:5
`define AEQC_B_FIRST_LOCK 4
`define AEQC_B_RESTART 3
`define AEQC_B_FLOOR_EN 2
`define AEQC_F_MAN_HI 7:5
`define AEQC_B_LOCK_WAIT 4
`define AEQC_F_MAN_LO 3:1
`define AEQC_B_BYPASS 0
`define AEQC_F_MAX 7:4
`define AEQC_F_FLOOR 3:0

// shortest relock wait in ns, the others double it
`define AEQC_RELOCK_BASE_NS 164000
`define AEQC_CLK_PERIOD_NS 10
`define AEQC_RELOCK_BASE_CYC (`AEQC_RELOCK_BASE_NS / `AEQC_CLK_PERIOD_NS)

`endif

// *** aeqc_relock_timer.v ***
// relock wait timer: pulses once the selected wait has elapsed
`timescale 1ns/1ps
`default_nettype none
`include "aeqc_defines.vh"
module aeqc_relock_timer #(
	parameter BASE_CYCLES = `AEQC_RELOCK_BASE_CYC,
	parameter CNT_W = 32
) (
	input wire i_clk,
	input wire i_rst_b,
	input wire i_restart,
	input wire [2:0] i_select,
	output reg o_expired
);
	reg [CNT_W-1:0] cnt_reg;
	wire [CNT_W-1:0] limit;
	// each code doubles the wait exactly; code 2 gives 656 us, code 7 about 21 ms
	assign limit = (BASE_CYCLES[CNT_W-1:0] << i_select) - {{(CNT_W-1){1'b0}}, 1'b1};
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_reg <= {CNT_W{1'b0}};
			o_expired <= 1'b0;
		end else if (i_restart) begin
			cnt_reg <= {CNT_W{1'b0}};
			o_expired <= 1'b0;
		end else if (cnt_reg >= limit) begin
			cnt_reg <= {CNT_W{1'b0}};
			o_expired <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
			o_expired <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** aeqc_top.v ***
// adaptive equalizer control, status and link test registers for one receive port
// What this block does
// - relock wait code selects 164us to 21ms
// - first lock restarts adaptation from zero
// - restart bit restarts adaptation, then self-clears
// - floor enable starts adaptation at floor
// - floor field gives starting gain, default 2
// - maximum field caps adaptive search, default f
// - bypass bit disables adaptive equalization
// - bypass setting built from two 3-bit fields
// - readback shows current setting, resets zero
// - flag shows remote self test active
// - continuous bit corrupts every back-channel frame
// - once bit corrupts exactly one frame
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "aeqc_defines.vh"
module aeqc_top #(
	parameter RELOCK_BASE_CYCLES = `AEQC_RELOCK_BASE_CYC
) (
	input wire i_clk,
	input wire i_rst_b,
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	input wire i_rx_lock_raw,
	input wire i_remote_selftest_active,
	input wire i_bc_frame_start,
	output reg [5:0] o_eq_setting,
	output reg o_rx_lock,
	output reg o_adapt_done,
	output reg o_bc_bit_error
);
	localparam ST_IDLE = 3'b001;
	localparam ST_SEARCH = 3'b010;
	localparam ST_LOCKED = 3'b100;

	reg [7:0] rsvd_bf_reg;
	reg [1:0] test_hi_reg;
	reg inj_cont_reg;
	reg inj_once_reg;
	reg [2:0] relock_sel_reg;
	reg first_lock_reg;
	reg restart_reg;
	reg floor_en_reg;
	reg [2:0] man_hi_reg;
	reg lock_wait_reg;
	reg [2:0] man_lo_reg;
	reg bypass_reg;
	reg [3:0] max_reg;
	reg [3:0] floor_reg;
	reg [5:0] setting_reg;
	reg [5:0] setting_next;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg seen_lock_reg;
	reg lock_d_reg;
	wire timer_expired;
	wire timer_restart;
	wire lock_rise;
	wire [5:0] start_value;
	wire wr_test;
	wire wr_ctl;
	wire wr_man;
	wire wr_lim;
	wire first_lock;

	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	assign wr_test = i_wr && hit(i_addr, `AEQC_ADDR_TEST_CTL);
	assign wr_ctl = i_wr && hit(i_addr, `AEQC_ADDR_ADAPT_CTL);
	assign wr_man = i_wr && hit(i_addr, `AEQC_ADDR_MANUAL);
	assign wr_lim = i_wr && hit(i_addr, `AEQC_ADDR_LIMITS);

	// register writes
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rsvd_bf_reg <= `AEQC_RST_RSVD_BF;
			test_hi_reg <= `AEQC_RST_TEST_HI;
			inj_cont_reg <= 1'b0;
			relock_sel_reg <= `AEQC_RST_RELOCK;
			first_lock_reg <= `AEQC_RST_FIRST_LOCK;
			floor_en_reg <= `AEQC_RST_FLOOR_EN;
			man_hi_reg <= `AEQC_RST_MAN_HI;
			lock_wait_reg <= `AEQC_RST_LOCK_WAIT;
			man_lo_reg <= `AEQC_RST_MAN_LO;
			bypass_reg <= `AEQC_RST_BYPASS;
			max_reg <= `AEQC_RST_MAX;
			floor_reg <= `AEQC_RST_FLOOR;
		end else begin
			if (i_wr && hit(i_addr, `AEQC_ADDR_RSVD_BF)) begin
				rsvd_bf_reg <= i_wdata;
			end
			if (wr_test) begin
				test_hi_reg <= i_wdata[`AEQC_F_TEST_HI];
				inj_cont_reg <= i_wdata[`AEQC_B_INJ_CONT];
			end
			if (wr_ctl) begin
				relock_sel_reg <= i_wdata[`AEQC_F_RELOCK];
				first_lock_reg <= i_wdata[`AEQC_B_FIRST_LOCK];
				floor_en_reg <= i_wdata[`AEQC_B_FLOOR_EN];
			end
			if (wr_man) begin
				man_hi_reg <= i_wdata[`AEQC_F_MAN_HI];
				lock_wait_reg <= i_wdata[`AEQC_B_LOCK_WAIT];
				man_lo_reg <= i_wdata[`AEQC_F_MAN_LO];
				bypass_reg <= i_wdata[`AEQC_B_BYPASS];
			end
			if (wr_lim) begin
				max_reg <= i_wdata[`AEQC_F_MAX];
				floor_reg <= i_wdata[`AEQC_F_FLOOR];
			end
		end
	end

	// restart is consumed one cycle after the write, so software may read it back as 1 once
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			restart_reg <= 1'b0;
		end else if (wr_ctl && i_wdata[`AEQC_B_RESTART]) begin
			restart_reg <= 1'b1;
		end else begin
			restart_reg <= 1'b0;
		end
	end

	// one-shot error request; a new write of 1 wins over the clear at frame start
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			inj_once_reg <= 1'b0;
			o_bc_bit_error <= 1'b0;
		end else begin
			o_bc_bit_error <= i_bc_frame_start && (inj_cont_reg || inj_once_reg);
			if (wr_test && i_wdata[`AEQC_B_INJ_ONCE]) begin
				inj_once_reg <= 1'b1;
			end else if (i_bc_frame_start) begin
				inj_once_reg <= 1'b0;
			end
		end
	end

	// floor only moves the start point; software keeps max above it
	assign start_value = floor_en_reg ? {2'b00, floor_reg} : 6'h00;
	assign lock_rise = i_rx_lock_raw && !lock_d_reg;
	assign first_lock = lock_rise && !seen_lock_reg;
	assign timer_restart = restart_reg || lock_rise || (state_reg != ST_SEARCH);

	aeqc_relock_timer #(
		.BASE_CYCLES(RELOCK_BASE_CYCLES),
		.CNT_W(32)
	) u_timer (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_restart(timer_restart),
		.i_select(relock_sel_reg),
		.o_expired(timer_expired)
	);

	// adaptation search
	always @* begin
		state_next = state_reg;
		setting_next = setting_reg;
		case (state_reg)
			ST_IDLE: begin
				state_next = ST_SEARCH;
				setting_next = start_value;
			end
			ST_SEARCH: begin
				if (i_rx_lock_raw) begin
					state_next = ST_LOCKED;
				end else if (timer_expired) begin
					if (setting_reg >= {2'b00, max_reg}) begin
						setting_next = start_value;
					end else begin
						setting_next = setting_reg + 6'h01;
					end
				end
			end
			ST_LOCKED: begin
				if (!i_rx_lock_raw) begin
					state_next = ST_SEARCH;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (first_lock && first_lock_reg) begin
			state_next = ST_SEARCH;
			setting_next = 6'h00;
		end
		if (restart_reg) begin
			state_next = ST_SEARCH;
			setting_next = start_value;
		end
		if (bypass_reg) begin
			state_next = ST_IDLE;
			setting_next = {man_hi_reg, man_lo_reg};
		end
	end

	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= ST_IDLE;
			setting_reg <= `AEQC_RST_SETTING;
			lock_d_reg <= 1'b0;
			seen_lock_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			setting_reg <= setting_next;
			lock_d_reg <= i_rx_lock_raw;
			if (lock_rise) begin
				seen_lock_reg <= 1'b1;
			end
		end
	end

	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_eq_setting <= `AEQC_RST_SETTING;
			o_adapt_done <= 1'b0;
			o_rx_lock <= 1'b0;
		end else begin
			o_eq_setting <= setting_next;
			o_adapt_done <= bypass_reg || (state_next == ST_LOCKED);
			if (lock_wait_reg) begin
				o_rx_lock <= i_rx_lock_raw && (bypass_reg || state_next == ST_LOCKED);
			end else begin
				o_rx_lock <= i_rx_lock_raw;
			end
		end
	end

	// read port: data one cycle after the strobe, zero otherwise
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				`AEQC_ADDR_RSVD_BF: o_rdata <= rsvd_bf_reg;
				`AEQC_ADDR_TEST_CTL: begin
					o_rdata <= {test_hi_reg, i_remote_selftest_active, 3'b000,
						inj_cont_reg, inj_once_reg};
				end
				`AEQC_ADDR_ADAPT_CTL: begin
					o_rdata <= {relock_sel_reg, first_lock_reg, restart_reg, floor_en_reg, 2'b00};
				end
				`AEQC_ADDR_READBACK: o_rdata <= {2'b00, setting_reg};
				`AEQC_ADDR_MANUAL: begin
					o_rdata <= {man_hi_reg, lock_wait_reg, man_lo_reg, bypass_reg};
				end
				`AEQC_ADDR_LIMITS: o_rdata <= {max_reg, floor_reg};
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// *** aeqc_top_assertions.sv ***
// port-level checker for the equalizer control block
`timescale 1ns/1ps
`default_nettype none
module aeqc_top_assertions (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_rx_lock_raw,
	input wire logic i_remote_selftest_active,
	input wire logic i_bc_frame_start,
	input wire logic [5:0] o_eq_setting,
	input wire logic o_rx_lock,
	input wire logic o_adapt_done,
	input wire logic o_bc_bit_error
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	property p_rdata_idle;
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_readback;
		i_rd && i_addr == 8'hd3 |=> o_rdata == {2'b00, $past(o_eq_setting)};
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");
	property p_selftest;
		i_rd && i_addr == 8'hd0 |=> o_rdata[5] == $past(i_remote_selftest_active);
	endproperty
	a_selftest: assert property (p_selftest) else $error("self test flag wrong");
	property p_bypass;
		i_wr && i_addr == 8'hd4 && i_wdata[0] |=> ##1
			o_eq_setting == {$past(i_wdata[7:5], 2), $past(i_wdata[3:1], 2)};
	endproperty
	a_bypass: assert property (p_bypass) else $error("manual setting wrong");
	property p_restart;
		i_wr && i_addr == 8'hd2 && i_wdata[3:2] == 2'b10 |=> ##1 o_eq_setting == 6'h00;
	endproperty
	a_restart: assert property (p_restart) else $error("restart not from zero");
	property p_lock;
		o_rx_lock |-> $past(i_rx_lock_raw);
	endproperty
	a_lock: assert property (p_lock) else $error("lock without detector");
	property p_err_cause;
		!i_bc_frame_start |=> !o_bc_bit_error;
	endproperty
	a_err_cause: assert property (p_err_cause) else $error("error without frame");
	sequence s_once;
		i_wr && i_addr == 8'hd0 && i_wdata == 8'h01 ##1 i_bc_frame_start && !i_wr;
	endsequence
	property p_once;
		s_once |=> o_bc_bit_error;
	endproperty
	a_once: assert property (p_once) else $error("single error missing");
	property p_once_only;
		s_once ##1 !i_wr ##1 i_bc_frame_start && !i_wr |=> !o_bc_bit_error;
	endproperty
	a_once_only: assert property (p_once_only) else $error("second error injected");
	c_err: cover property (o_bc_bit_error);
	c_lock: cover property (o_rx_lock);
	c_manual: cover property (o_adapt_done && o_eq_setting == 6'h2a);
endmodule
`default_nettype wire

// *** aeqc_remote_model.sv ***
// far-end serializer stand-in: lock detector level and back-channel frame pulses
`timescale 1ns/1ps
`default_nettype none
module aeqc_remote_model #(
	parameter int LOCK_DLY = 3
) (
	input wire logic i_clk,
	input wire logic i_link_up,
	input wire logic i_frames_on,
	output logic o_lock,
	output logic o_frame
);
	int cnt = 0;
	initial o_lock = 1'b0;
	initial o_frame = 1'b0;
	// frames every other cycle so single-shot and continuous counts are exact
	always @(posedge i_clk) begin
		cnt <= i_link_up ? cnt + 1 : 0;
		o_lock <= i_link_up && cnt >= LOCK_DLY;
		o_frame <= i_frames_on && !o_frame;
	end
endmodule
`default_nettype wire

// *** aeqc_top_tb.sv ***
// self-checking bench for the equalizer control block
`timescale 1ns/1ps
`default_nettype none
module aeqc_top_tb;
	logic clk, rst_b, wr, rd, link_up, frames_on, selftest, lock_raw, frame;
	logic rx_lock, done, bc_err;
	logic [7:0] addr, wdata, rdata;
	logic [5:0] eq;
	int err_count = 0;
	int n_checks = 0;
	int hits;
	logic [7:0] ra [6] = '{8'hd0, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hbf};
	logic [7:0] rv [6] = '{8'h00, 8'h94, 8'h02, 8'h60, 8'hf2, 8'h00};
	aeqc_top #(.RELOCK_BASE_CYCLES(10)) uut (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_lock_raw(lock_raw),
		.i_remote_selftest_active(selftest), .i_bc_frame_start(frame), .o_eq_setting(eq),
		.o_rx_lock(rx_lock), .o_adapt_done(done), .o_bc_bit_error(bc_err));
	aeqc_remote_model far (.i_clk(clk), .i_link_up(link_up), .i_frames_on(frames_on),
		.o_lock(lock_raw), .o_frame(frame));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic results;
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp(rdata, e);
	endtask
	// waits for the next change of the applied setting, bounded
	task automatic step_to(input logic [5:0] e);
		logic [5:0] old;
		old = eq;
		for (int i = 0; i < 400 && eq === old; i++) begin
			@(posedge clk);
			#1;
		end
		cmp({2'b00, eq}, {2'b00, e});
	endtask
	task automatic settle(input logic [5:0] e);
		repeat (2) @(posedge clk);
		#1 cmp({2'b00, eq}, {2'b00, e});
	endtask
	task automatic count_err(input logic [7:0] e);
		hits = 0;
		repeat (40) begin
			@(posedge clk);
			#1 hits += bc_err;
		end
		cmp(hits[7:0], e);
	endtask
	initial begin
		#300000;
		err_count++;
		results();
	end
	initial begin
		{rst_b, wr, rd, link_up, frames_on, selftest} = '0;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++) rd_reg(ra[i], rv[i]);
		wr_reg(8'hd3, 8'hff);
		rd_reg(8'hd3, 8'h02);
		wr_reg(8'hbf, 8'h5a);
		rd_reg(8'hbf, 8'h5a);
		wr_reg(8'hc0, 8'h55);
		rd_reg(8'hc0, 8'h00);
		wr_reg(8'hd5, 8'h51);
		rd_reg(8'hd5, 8'h51);
		wr_reg(8'hd2, 8'h0b);
		settle(6'h00);
		for (int v = 1; v < 6; v++) step_to(v[5:0]);
		step_to(6'h00);
		rd_reg(8'hd2, 8'h00);
		wr_reg(8'hd2, 8'h0c);
		settle(6'h01);
		for (int v = 2; v < 6; v++) step_to(v[5:0]);
		step_to(6'h01);
		link_up <= 1'b1;
		wr_reg(8'hd4, 8'hb5);
		settle(6'h2a);
		repeat (6) @(posedge clk);
		#1 cmp({6'h00, rx_lock, done}, 8'h03);
		wr_reg(8'hd4, 8'h00);
		frames_on <= 1'b1;
		selftest <= 1'b1;
		// one extra edge puts a frame start just before the one-shot write and the next one right after it
		@(posedge clk);
		wr_reg(8'hd0, 8'h01);
		count_err(8'd1);
		rd_reg(8'hd0, 8'h20);
		wr_reg(8'hd0, 8'hc2);
		count_err(8'd20);
		rd_reg(8'hd0, 8'he2);
		rst_b <= 1'b0;
		link_up <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		settle(6'h02);
		link_up <= 1'b1;
		step_to(6'h00);
		#1 cmp({7'h00, rx_lock}, 8'h01);
		results();
	end
endmodule
bind aeqc_top aeqc_top_assertions chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_rx_lock_raw(i_rx_lock_raw), .i_remote_selftest_active(i_remote_selftest_active),
	.i_bc_frame_start(i_bc_frame_start), .o_eq_setting(o_eq_setting), .o_rx_lock(o_rx_lock),
	.o_adapt_done(o_adapt_done), .o_bc_bit_error(o_bc_bit_error));
`default_nettype wire
